// *** common/data_rom_pkg.sv ***
// Purpose: constants for the data ROM nibble read port and its watchdog
// Assumes: clk_in is the system clock, 20 MHz
// Notes: register offsets are special-register addresses of the 4-bit core
package data_rom_pkg;
  localparam int ADDR_W = 5;
  localparam int NIB_W = 4;
  localparam int ROM_ADDR_W = 16;
  localparam int ROM_DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_ADDR_NIB0 = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_ADDR_NIB1 = 5'h19;
  localparam logic [ADDR_W-1:0] OFS_ADDR_NIB2 = 5'h1A;
  localparam logic [ADDR_W-1:0] OFS_ADDR_NIB3 = 5'h1B;
  localparam logic [ADDR_W-1:0] OFS_DATA_LOW = 5'h1C;
  localparam logic [ADDR_W-1:0] OFS_DATA_HIGH = 5'h1D;
  localparam logic [NIB_W-1:0] NIB_RESET = 4'h0;
  localparam logic [ROM_ADDR_W-1:0] ROM_ADDR_RESET = 16'h0000;
  // reserved system area, left to the assembler to police
  localparam logic [ROM_ADDR_W-1:0] ROM_SYS_AREA_FIRST = 16'hDFC0;
  localparam logic [ROM_ADDR_W-1:0] ROM_SYS_AREA_LAST = 16'hDFFF;
  // ready time is two system clock periods; clk_in is the system clock
  localparam int DATA_ROM_READY_PERIODS = 2;
  localparam int DATA_ROM_READY_CLKS = DATA_ROM_READY_PERIODS;
  // watchdog period 256*256*16 system clocks
  localparam int WDOG_PERIOD_CLKS = 256 * 256 * 16;
  localparam int WDOG_CNT_W = 21;
endpackage : data_rom_pkg

// *** common/wdog_if.sv ***
// Purpose: link between the read port and its watchdog counter
// Assumes: single clock domain
// Notes: clear and expire are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface wdog_if;
  logic enable;
  logic clear;
  logic expire;
  modport ctrl (output enable, output clear, input expire);
  modport timer (input enable, input clear, output expire);
endinterface : wdog_if
`default_nettype wire

// *** verilog/wdog_timer.sv ***
// Purpose: watchdog counter that raises a system reset pulse on overflow
// Assumes: enable is a static configuration option level
// Notes: counter held at zero while disabled
`timescale 1ns/1ps
`default_nettype none
module wdog_timer #(
  parameter int PERIOD_CLKS = data_rom_pkg::WDOG_PERIOD_CLKS
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // control
  wdog_if.timer wd
);
  import data_rom_pkg::*;
  logic [WDOG_CNT_W-1:0] cnt_r;
  logic expire_r;
  localparam logic [WDOG_CNT_W-1:0] LAST = WDOG_CNT_W'(PERIOD_CLKS - 1);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= '0;
    end else if (!wd.enable || wd.clear) begin
      cnt_r <= '0;
    end else if (cnt_r == LAST) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // expiry reported as one pulse; clear in the same cycle wins the race
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      expire_r <= 1'b0;
    end else begin
      expire_r <= wd.enable && !wd.clear && (cnt_r == LAST);
    end
  end

  assign wd.expire = expire_r;
endmodule : wdog_timer
`default_nettype wire

// *** verilog/data_rom_nibble_read_port.sv ***
// Purpose: special-register read port onto the data ROM, plus watchdog clear
// Assumes: ROM array answers combinationally to rom_addr_out
// Notes: data latch refreshed one clock after any address nibble write
`timescale 1ns/1ps
`default_nettype none
module data_rom_nibble_read_port #(
  parameter int WDOG_PERIOD_CLKS = data_rom_pkg::WDOG_PERIOD_CLKS
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // special-register port from the core
  input wire logic [data_rom_pkg::ADDR_W-1:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [data_rom_pkg::NIB_W-1:0] sfr_wdata_in,
  output logic [data_rom_pkg::NIB_W-1:0] sfr_rdata_out,
  // data ROM array
  output logic [data_rom_pkg::ROM_ADDR_W-1:0] rom_addr_out,
  input wire logic [data_rom_pkg::ROM_DATA_W-1:0] rom_data_in,
  // watchdog option and system reset request
  input wire logic wdog_enable_in,
  output logic sys_reset_out
);
  import data_rom_pkg::*;

  // one clock of settling after an address write, then the byte is latched
  typedef enum logic {
    CAP_IDLE,
    CAP_SETTLE
  } cap_state_t;

  // which register a single strobe hits
  typedef struct packed {
    logic [3:0] nib;
    logic data_low;
    logic data_high;
  } reg_hit_t;

  logic [NIB_W-1:0] nib0_r;
  logic [NIB_W-1:0] nib1_r;
  logic [NIB_W-1:0] nib2_r;
  logic [NIB_W-1:0] nib3_r;
  logic [ROM_ADDR_W-1:0] rom_addr;
  logic [NIB_W-1:0] data_low_r;
  logic [NIB_W-1:0] data_high_r;
  logic [ROM_DATA_W-1:0] data_byte;
  cap_state_t cap_state_r;
  cap_state_t cap_state_nxt;
  logic capture;
  logic [NIB_W-1:0] rdata_r;
  logic [NIB_W-1:0] rdata_nxt;
  reg_hit_t wr_hit;
  logic addr_wr;
  wdog_if wd ();

  // index 0..3 of an address nibble register, or 4 for none
  function automatic logic [2:0] nib_index(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_ADDR_NIB0: nib_index = 3'h0;
      OFS_ADDR_NIB1: nib_index = 3'h1;
      OFS_ADDR_NIB2: nib_index = 3'h2;
      OFS_ADDR_NIB3: nib_index = 3'h3;
      default: nib_index = 3'h4;
    endcase
  endfunction : nib_index

  function automatic logic [NIB_W-1:0] read_mux(
    input logic [ADDR_W-1:0] a,
    input logic [ROM_ADDR_W-1:0] ad,
    input logic [ROM_DATA_W-1:0] d
  );
    logic [2:0] i;
    i = nib_index(a);
    if (i != 3'h4) begin
      read_mux = ad[i[1:0]*NIB_W +: NIB_W];
    end else if (a == OFS_DATA_LOW) begin
      read_mux = d[3:0];
    end else if (a == OFS_DATA_HIGH) begin
      read_mux = d[7:4];
    end else begin
      read_mux = 4'h0;
    end
  endfunction : read_mux

  function automatic reg_hit_t decode_hit(
    input logic strobe,
    input logic [ADDR_W-1:0] a
  );
    reg_hit_t h;
    logic [2:0] i;
    h = '0;
    i = nib_index(a);
    if (strobe && i != 3'h4) begin
      h.nib[i[1:0]] = 1'b1;
    end
    h.data_low = strobe && (a == OFS_DATA_LOW);
    h.data_high = strobe && (a == OFS_DATA_HIGH);
    decode_hit = h;
  endfunction : decode_hit

  assign wr_hit = decode_hit(sfr_wr_in, sfr_addr_in);
  assign addr_wr = |wr_hit.nib;

  // lowest offset is the least significant nibble
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      nib0_r <= NIB_RESET;
    end else if (wr_hit.nib[0]) begin
      nib0_r <= sfr_wdata_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      nib1_r <= NIB_RESET;
    end else if (wr_hit.nib[1]) begin
      nib1_r <= sfr_wdata_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      nib2_r <= NIB_RESET;
    end else if (wr_hit.nib[2]) begin
      nib2_r <= sfr_wdata_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      nib3_r <= NIB_RESET;
    end else if (wr_hit.nib[3]) begin
      nib3_r <= sfr_wdata_in;
    end
  end

  // no range check: the reserved system area reads like any other
  assign rom_addr = {nib3_r, nib2_r, nib1_r, nib0_r};

  // rewriting any nibble restarts the access at the new address
  always_comb begin
    cap_state_nxt = cap_state_r;
    case (cap_state_r)
      CAP_IDLE: begin
        if (addr_wr) begin
          cap_state_nxt = CAP_SETTLE;
        end
      end
      CAP_SETTLE: begin
        if (!addr_wr) begin
          cap_state_nxt = CAP_IDLE;
        end
      end
      default: begin
        cap_state_nxt = CAP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cap_state_r <= CAP_IDLE;
    end else begin
      cap_state_r <= cap_state_nxt;
    end
  end

  assign capture = (cap_state_r == CAP_SETTLE);

  // capture beats a software write to the latch in the same cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_low_r <= NIB_RESET;
    end else if (capture) begin
      data_low_r <= rom_data_in[3:0];
    end else if (wr_hit.data_low) begin
      data_low_r <= sfr_wdata_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_high_r <= NIB_RESET;
    end else if (capture) begin
      data_high_r <= rom_data_in[7:4];
    end else if (wr_hit.data_high) begin
      data_high_r <= sfr_wdata_in;
    end
  end

  assign data_byte = {data_high_r, data_low_r};

  // read data held until the next read; a read beside a write sees the old value
  always_comb begin
    rdata_nxt = rdata_r;
    if (sfr_rd_in) begin
      rdata_nxt = read_mux(sfr_addr_in, rom_addr, data_byte);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_r <= NIB_RESET;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign wd.enable = wdog_enable_in;
  assign wd.clear = wr_hit.data_high && wdog_enable_in;

  wdog_timer #(
    .PERIOD_CLKS(WDOG_PERIOD_CLKS)
  ) u_wdog (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .wd(wd)
  );

  assign rom_addr_out = rom_addr;
  assign sfr_rdata_out = rdata_r;
  assign sys_reset_out = wd.expire;
endmodule : data_rom_nibble_read_port
`default_nettype wire

// *** tb/rom_model.sv ***
// Purpose: data ROM array model
// Assumes: asynchronous read
// Notes: byte mixes both address halves
`timescale 1ns/1ps
`default_nettype none
module rom_model (
  // array port
  input wire logic [15:0] addr_in,
  output logic [7:0] data_out
);
  assign data_out = addr_in[7:0] ^ {addr_in[11:8], addr_in[15:12]} ^ 8'h3C;
endmodule : rom_model
`default_nettype wire

// *** tb/data_rom_props.sv ***
// Purpose: port checks of the read port
// Assumes: period above 8 clocks
// Notes: reads judged after quiet cycles
`timescale 1ns/1ps
`default_nettype none
module data_rom_props import data_rom_pkg::*; #(parameter int WDOG_PERIOD_CLKS = 16) (
  // watched ports
  input wire logic clk_in, rst_in, sfr_wr_in, sfr_rd_in, wdog_enable_in, sys_reset_out,
  input wire logic [ADDR_W-1:0] sfr_addr_in,
  input wire logic [NIB_W-1:0] sfr_wdata_in, sfr_rdata_out,
  input wire logic [ROM_ADDR_W-1:0] rom_addr_out,
  input wire logic [ROM_DATA_W-1:0] rom_data_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_nib0_load: assert property (sfr_wr_in && sfr_addr_in == OFS_ADDR_NIB0
    |=> rom_addr_out[3:0] == $past(sfr_wdata_in)) else $error("nibble 0");
  a_nib3_load: assert property (sfr_wr_in && sfr_addr_in == OFS_ADDR_NIB3
    |=> rom_addr_out[15:12] == $past(sfr_wdata_in)) else $error("nibble 3");
  a_low_read: assert property (!sfr_wr_in [*3] ##1
    (sfr_rd_in && sfr_addr_in == OFS_DATA_LOW) |=> sfr_rdata_out == $past(rom_data_in[3:0]))
    else $error("low data");
  a_high_read: assert property (!sfr_wr_in [*3] ##1
    (sfr_rd_in && sfr_addr_in == OFS_DATA_HIGH) |=> sfr_rdata_out == $past(rom_data_in[7:4]))
    else $error("high data");
  a_data_hold: assert property (!sfr_rd_in |=> $stable(sfr_rdata_out))
    else $error("read data moved");
  a_wdog_off: assert property (!wdog_enable_in && !$past(wdog_enable_in)
    |-> !sys_reset_out) else $error("reset while off");
  a_pulse_one: assert property (sys_reset_out |=> !sys_reset_out)
    else $error("long reset");
  a_wdog_clear: assert property (sfr_wr_in && wdog_enable_in &&
    sfr_addr_in == OFS_DATA_HIGH |=> !sys_reset_out [*8]) else $error("clear ignored");
endmodule : data_rom_props
bind data_rom_nibble_read_port data_rom_props #(.WDOG_PERIOD_CLKS(WDOG_PERIOD_CLKS)) u_data_rom_props (
  .clk_in, .rst_in, .sfr_wr_in, .sfr_rd_in, .wdog_enable_in, .sys_reset_out, .sfr_addr_in,
  .sfr_wdata_in, .sfr_rdata_out, .rom_addr_out, .rom_data_in);
`default_nettype wire

// *** tb/testbench.sv ***
// Purpose: register test of the read port
// Assumes: watchdog period cut to 16
// Notes: reads wait the ready time
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import data_rom_pkg::*;
  logic clk_in = 1'h0, rst_in = 1'h1, sfr_wr_in = 1'h0, sfr_rd_in = 1'h0, wdog_enable_in = 1'h0;
  logic [ADDR_W-1:0] sfr_addr_in = 5'h00;
  logic [NIB_W-1:0] sfr_wdata_in = 4'h0, sfr_rdata_out;
  logic [ROM_ADDR_W-1:0] rom_addr_out, a;
  logic [ROM_DATA_W-1:0] rom_data_in, b;
  logic sys_reset_out;
  int n_fail = 0, check_count = 0, i, j, k;
  always #25 clk_in = ~clk_in;
  rom_model u_rom_model (.addr_in(rom_addr_out), .data_out(rom_data_in));
  data_rom_nibble_read_port #(.WDOG_PERIOD_CLKS(16)) u_data_rom_nibble_read_port (.clk_in,
    .rst_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out,
    .rom_addr_out, .rom_data_in, .wdog_enable_in, .sys_reset_out);
  task automatic chk(input logic [15:0] g, e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // one request per edge, so no strobe is assigned twice in a step
  task automatic op(input logic w, r, input logic [4:0] ad, input logic [3:0] d);
    sfr_wr_in <= w;
    sfr_rd_in <= r;
    sfr_addr_in <= ad;
    sfr_wdata_in <= d;
    @(posedge clk_in);
  endtask : op
  task automatic rd(input logic [4:0] ad, input logic [3:0] e);
    op(1'h0, 1'h1, ad, 4'h0);
    op(1'h0, 1'h0, ad, 4'h0);
    chk(16'(sfr_rdata_out), 16'(e));
  endtask : rd
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'h0;
    for (i = 0; i < 3; i++) begin
      a = 16'h0234 | (16'(i * 5 + 1) << 12);
      b = a[7:0] ^ {a[11:8], a[15:12]} ^ 8'h3C;
      for (j = 0; j < 4; j++)
        if (i == 0 || j == 3) op(1'h1, 1'h0, OFS_ADDR_NIB0 + 5'(j), a[4*j+:4]);
      op(1'h0, 1'h0, 5'h00, 4'h0);
      for (k = 0; k < 4; k++)
        rd(k[0] ? OFS_DATA_HIGH : OFS_DATA_LOW, b[4*k[0]+:4]);
      for (j = 0; j < 4; j++) rd(OFS_ADDR_NIB0 + 5'(j), a[4*j+:4]);
      chk(rom_addr_out, a);
    end
    rd(5'h1E, 4'h0);
    op(1'h1, 1'h0, OFS_DATA_LOW, 4'hA);
    rd(OFS_DATA_LOW, 4'hA);
    $display("test rom reads done");
    wdog_enable_in <= 1'h1;
    for (i = 0; i < 40; i++) begin
      op(i % 10 == 0, 1'h0, OFS_DATA_HIGH, 4'h5);
      chk(16'(sys_reset_out), 16'h0);
    end
    k = 0;
    while (sys_reset_out !== 1'h1 && k < 40) begin
      op(1'h0, 1'h0, 5'h00, 4'h0);
      k++;
    end
    chk(16'(k < 40), 16'h1);
    if (k < 40) begin
      $display("test watchdog done");
    end
    tally_and_finish;
  end
endmodule : testbench
`default_nettype wire
